// ### hrpm_pkg.sv
// Shared constants and types of the host read prefetch and address map block, plus its address decoder.
// Assumes a single 10 MHz clock and word addresses of fifteen bits.

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package hrpm_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int SPI_CNT_W = 4;
  localparam logic [14:0] ADDR_ONE = 15'h0001;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
  localparam logic [3:0] SPI_LAST_BIT = 4'hF;
  localparam int SPI_RD_BIT = 15;

  // Region bases; each region ends just below the next base.
  localparam logic [14:0] BASE_RSVD = 15'h0050;
  localparam logic [14:0] BASE_CALL_STACK = 15'h0054;
  localparam logic [14:0] BASE_MON_TMP_A = 15'h005C;
  localparam logic [14:0] BASE_MON_TMP_B = 15'h0086;
  localparam logic [14:0] BASE_MON_LIST_A = 15'h00B0;
  localparam logic [14:0] BASE_MON_LIST_B = 15'h00B8;
  localparam logic [14:0] BASE_CTL_QUEUE = 15'h00C0;
  localparam logic [14:0] BASE_MON_FILTER = 15'h0100;
  localparam logic [14:0] BASE_IRQ_LOG = 15'h0180;
  localparam logic [14:0] BASE_RT1_RXBUF = 15'h01C0;
  localparam logic [14:0] BASE_RT2_RXBUF = 15'h01E0;
  localparam logic [14:0] BASE_RT1_ILLEG = 15'h0200;
  localparam logic [14:0] BASE_RT2_ILLEG = 15'h0300;
  localparam logic [14:0] BASE_RT1_DESC = 15'h0400;
  localparam logic [14:0] BASE_RT2_DESC = 15'h0600;
  localparam logic [14:0] BASE_GEN_RAM = 15'h0800;

  // Interrupt log walks two-word entries through its 64-word buffer.
  localparam logic [14:0] LOG_LAST_ENTRY = 15'h01BE;
  localparam logic [14:0] LOG_STEP = 15'h0002;

  typedef enum logic [3:0] {
    HRPM_RG_REGS = 4'h0,
    HRPM_RG_RSVD = 4'h1,
    HRPM_RG_CALL_STACK = 4'h2,
    HRPM_RG_MON_TMP_A = 4'h3,
    HRPM_RG_MON_TMP_B = 4'h4,
    HRPM_RG_MON_LIST_A = 4'h5,
    HRPM_RG_MON_LIST_B = 4'h6,
    HRPM_RG_CTL_QUEUE = 4'h7,
    HRPM_RG_MON_FILTER = 4'h8,
    HRPM_RG_IRQ_LOG = 4'h9,
    HRPM_RG_RT1_RXBUF = 4'hA,
    HRPM_RG_RT2_RXBUF = 4'hB,
    HRPM_RG_RT1_ILLEG = 4'hC,
    HRPM_RG_RT2_ILLEG = 4'hD,
    HRPM_RG_DESC = 4'hE,
    HRPM_RG_GEN_RAM = 4'hF
  } hrpm_region_type;

  // Gray order along idle, fetch, prefetch.
  typedef enum logic [1:0] {
    HRPM_ST_IDLE = 2'b00,
    HRPM_ST_FETCH = 2'b01,
    HRPM_ST_PREF = 2'b11,
    HRPM_ST_SPARE = 2'b10
  } hrpm_fsm_type;
endpackage

// ----------------------------------------------------------------------------
// Address decoder
// ----------------------------------------------------------------------------
module hrpm_addr_map
  import hrpm_pkg::*;
(
  input wire logic [14:0] i_addr,
  output hrpm_region_type o_region
);
  function automatic hrpm_region_type decode(input logic [14:0] a);
    hrpm_region_type r;
    r = HRPM_RG_GEN_RAM;
    if (a < BASE_RSVD) r = HRPM_RG_REGS; // [RL10]
    else if (a < BASE_CALL_STACK) r = HRPM_RG_RSVD; // [RL10]
    else if (a < BASE_MON_TMP_A) r = HRPM_RG_CALL_STACK; // [RL11]
    else if (a < BASE_MON_TMP_B) r = HRPM_RG_MON_TMP_A; // [RL12]
    else if (a < BASE_MON_LIST_A) r = HRPM_RG_MON_TMP_B; // [RL12]
    else if (a < BASE_MON_LIST_B) r = HRPM_RG_MON_LIST_A; // [RL13]
    else if (a < BASE_CTL_QUEUE) r = HRPM_RG_MON_LIST_B; // [RL13]
    else if (a < BASE_MON_FILTER) r = HRPM_RG_CTL_QUEUE; // [RL13]
    else if (a < BASE_IRQ_LOG) r = HRPM_RG_MON_FILTER; // [RL14]
    else if (a < BASE_RT1_RXBUF) r = HRPM_RG_IRQ_LOG; // [RL15]
    else if (a < BASE_RT2_RXBUF) r = HRPM_RG_RT1_RXBUF; // [RL15]
    else if (a < BASE_RT1_ILLEG) r = HRPM_RG_RT2_RXBUF; // [RL15]
    else if (a < BASE_RT2_ILLEG) r = HRPM_RG_RT1_ILLEG; // [RL16]
    else if (a < BASE_RT1_DESC) r = HRPM_RG_RT2_ILLEG; // [RL16]
    else if (a < BASE_GEN_RAM) r = HRPM_RG_DESC; // [RL17]
    else r = HRPM_RG_GEN_RAM; // [RL18]
    return r;
  endfunction

  // The active descriptor table is picked by a base register elsewhere; both defaults decode alike.
  assign o_region = decode(i_addr);
endmodule

// ### hrpm_host_port.sv
// Host access front end: parallel bus or serial slave port, read prefetch, wait output, address map.
// Assumes shared storage outside with one-cycle read latency on the same clock as this block.
//
// What this block does
// (RL1) A read missing the prefetch holds wait active until its word is fetched.
// (RL2) After each read, the next sequential word is fetched and held.
// (RL3) A read of the held address returns held data with no wait, however late.
// (RL4) Any host write invalidates the held prefetch word.
// (RL5) Every read starts a prefetch of the following address, needed or not.
// (RL6) Wait output active level follows the polarity strap.
// (RL7) Serial port is slave only; host select low enables each access.
// (RL8) Serial output is driven only while shifting data toward the host.
// (RL9) Host port strap selects the parallel bus or the serial port.
// (RL10) Words 0x0000-0x004F are registers; 0x0050-0x0053 are reserved.
// (RL11) Words 0x0054-0x005B are the controller call stack.
// (RL12) Words 0x005C-0x0085 and 0x0086-0x00AF are monitor temporary buffers.
// (RL13) 0x00B0-0x00BF are monitor address lists; 0x00C0-0x00FF controller queue.
// (RL14) Words 0x0100-0x017F are the monitor message filter table.
// (RL15) 0x0180-0x01BF interrupt log; 0x01C0-0x01FF two terminal receive buffers.
// (RL16) Words 0x0200-0x03FF are the two command illegalisation tables.
// (RL17) Words 0x0400-0x07FF are the two default descriptor tables.
// (RL18) Words 0x0800-0x7FFF are host-allocated general RAM.
// (RL19) Interrupt log pointer resets to 0x0180 and advances one entry per interrupt.
// (RL20) Both ports share one decoder and one prefetch for registers and RAM.

module hrpm_host_port
  import hrpm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_bus_sel,
  input wire logic i_hold_off_polarity_strap,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [14:0] i_addr,
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_data_oe,
  output logic o_wait,
  input wire logic i_ss_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [14:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  input wire logic [15:0] i_mem_rdata,
  output hrpm_region_type o_mem_region,
  input wire logic i_irq_log_advance,
  output logic [14:0] o_irq_log_ptr
);
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pin1;
    logic [7:0] pin2;
    logic [14:0] addr1;
    logic [14:0] addr2;
    logic [15:0] data1;
    logic [15:0] data2;
    logic rd_act;
    logic wr_act;
    logic sck_d;
    hrpm_fsm_type fsm;
    logic wait_act;
    logic wait_pin;
    logic pend_rd;
    logic pend_wr;
    logic [14:0] pend_addr;
    logic [15:0] pend_wdata;
    logic [14:0] cur_addr;
    logic [15:0] rdata;
    logic rdy;
    logic pf_valid;
    logic [14:0] pf_addr;
    logic [15:0] pf_data;
    logic mem_rd;
    logic mem_wr;
    logic [14:0] mem_addr;
    logic [15:0] mem_wdata;
    hrpm_region_type region;
    logic par_oe;
    logic [15:0] spi_in;
    logic [3:0] spi_cnt;
    logic spi_phase;
    logic spi_is_rd;
    logic [14:0] spi_addr;
    logic [15:0] spi_out;
    logic so_oe;
    logic [14:0] log_ptr;
  } hrpm_state_type;

  hrpm_state_type st;
  hrpm_state_type next_st;
  hrpm_region_type cur_region;

  // Synchronised pin vector: {bus_sel, pol, ce_n, oe_n, we_n, ss_n, sck, si}.
  logic bus_sel_s;
  logic pol_s;
  logic ce_s;
  logic oe_s;
  logic we_s;
  logic ss_s;
  logic sck_s;
  logic si_s;
  assign {bus_sel_s, pol_s, ce_s, oe_s, we_s, ss_s, sck_s, si_s} = st.pin2;

  hrpm_addr_map u_map (
    .i_addr(st.mem_addr),
    .o_region(cur_region)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic rd_now;
    logic wr_now;
    logic req_rd;
    logic req_wr;
    logic [14:0] req_addr;
    logic [15:0] req_wdata;
    logic hit;
    logic [15:0] mem_data;
    rd_now = 1'b0;
    wr_now = 1'b0;
    req_rd = 1'b0;
    req_wr = 1'b0;
    req_addr = st.addr2;
    req_wdata = st.data2;
    hit = 1'b0;
    mem_data = i_mem_rdata;
    next_st = st;
    next_st.pin1 = {i_bus_sel, i_hold_off_polarity_strap, i_ce_n, i_oe_n, i_we_n, i_ss_n, i_sck, i_si};
    next_st.pin2 = st.pin1;
    next_st.addr1 = i_addr;
    next_st.addr2 = st.addr1;
    next_st.data1 = i_data;
    next_st.data2 = st.data1;
    next_st.mem_rd = 1'b0;
    next_st.mem_wr = 1'b0;
    next_st.rdy = 1'b0;
    next_st.region = cur_region;

    // Parallel port: a read starts on strobe assertion, a write is taken at strobe release.
    rd_now = bus_sel_s && !ce_s && !oe_s; // [RL9]
    wr_now = bus_sel_s && !ce_s && !we_s;
    next_st.rd_act = rd_now;
    next_st.wr_act = wr_now;
    next_st.par_oe = rd_now;
    if (rd_now && !st.rd_act) begin
      req_rd = 1'b1;
    end
    if (!wr_now && st.wr_act) begin
      req_wr = 1'b1;
    end

    // Serial slave port, mode 0: sample on rising SCK, shift out on falling SCK.
    next_st.sck_d = sck_s;
    if (bus_sel_s || ss_s) begin // [RL7]
      next_st.spi_cnt = 4'h0;
      next_st.spi_phase = 1'b0;
      next_st.so_oe = 1'b0;
    end else begin
      if (sck_s && !st.sck_d) begin
        next_st.spi_in = {st.spi_in[14:0], si_s};
        next_st.spi_cnt = st.spi_cnt + 4'h1;
        if (st.spi_cnt == SPI_LAST_BIT) begin
          if (!st.spi_phase) begin
            next_st.spi_phase = 1'b1;
            next_st.spi_is_rd = st.spi_in[SPI_RD_BIT - 1];
            next_st.spi_addr = {st.spi_in[13:0], si_s};
            req_addr = {st.spi_in[13:0], si_s};
            req_rd = st.spi_in[SPI_RD_BIT - 1];
          end else if (st.spi_is_rd) begin
            next_st.spi_addr = st.spi_addr + ADDR_ONE;
            req_addr = st.spi_addr + ADDR_ONE;
            req_rd = 1'b1;
          end else begin
            next_st.spi_addr = st.spi_addr + ADDR_ONE;
            req_addr = st.spi_addr;
            req_wdata = {st.spi_in[14:0], si_s};
            req_wr = 1'b1;
          end
        end
      end
      // The last falling edge of a word, after its sixteenth rising edge, is skipped so the loaded MSB is not lost.
      if (!sck_s && st.sck_d && st.spi_cnt != 4'h0) begin
        next_st.spi_out = {st.spi_out[14:0], 1'b0};
      end
      next_st.so_oe = st.spi_phase && st.spi_is_rd; // [RL8]
    end
    if (!bus_sel_s && st.rdy) begin
      next_st.spi_out = st.rdata;
    end

    // Both ports feed one pending request slot and one prefetch. [RL20]
    if (req_rd) begin
      next_st.pend_rd = 1'b1;
      next_st.pend_addr = req_addr;
    end
    if (req_wr) begin
      next_st.pend_wr = 1'b1;
      next_st.pend_addr = req_addr;
      next_st.pend_wdata = req_wdata;
    end

    // Reserved words read back as zero.
    if (cur_region == HRPM_RG_RSVD) begin // [RL10]
      mem_data = DATA_ZERO;
    end
    hit = st.pf_valid && (st.pend_addr == st.pf_addr);

    case (st.fsm)
      HRPM_ST_IDLE: begin
        if (st.pend_wr) begin
          next_st.pend_wr = req_wr;
          next_st.mem_wr = 1'b1;
          next_st.mem_addr = st.pend_addr;
          next_st.mem_wdata = st.pend_wdata;
          next_st.pf_valid = 1'b0; // [RL4]
        end else if (st.pend_rd) begin
          next_st.pend_rd = req_rd;
          next_st.cur_addr = st.pend_addr;
          if (hit) begin
            next_st.rdata = st.pf_data; // [RL3]
            next_st.rdy = 1'b1;
            next_st.mem_rd = 1'b1;
            next_st.mem_addr = st.pend_addr + ADDR_ONE; // [RL5]
            next_st.fsm = HRPM_ST_PREF;
          end else begin
            next_st.wait_act = 1'b1; // [RL1]
            next_st.mem_rd = 1'b1;
            next_st.mem_addr = st.pend_addr;
            next_st.fsm = HRPM_ST_FETCH;
          end
        end
      end
      HRPM_ST_FETCH: begin
        // Storage answers the cycle after its strobe, so the strobe cycle itself only waits.
        if (!st.mem_rd) begin
          next_st.rdata = mem_data;
          next_st.rdy = 1'b1;
          next_st.wait_act = 1'b0; // [RL1]
          next_st.mem_rd = 1'b1;
          next_st.mem_addr = st.cur_addr + ADDR_ONE; // [RL2]
          next_st.fsm = HRPM_ST_PREF;
        end
      end
      HRPM_ST_PREF: begin
        // A write that slipped in while fetching leaves the held word invalid.
        if (!st.mem_rd) begin
          next_st.pf_data = mem_data; // [RL2]
          next_st.pf_addr = st.mem_addr;
          next_st.pf_valid = !st.pend_wr; // [RL4]
          next_st.fsm = HRPM_ST_IDLE;
        end
      end
      default: begin
        next_st.fsm = HRPM_ST_IDLE;
        next_st.wait_act = 1'b0;
      end
    endcase

    next_st.wait_pin = next_st.wait_act ? pol_s : !pol_s; // [RL6]

    if (i_irq_log_advance) begin
      if (st.log_ptr >= LOG_LAST_ENTRY) begin
        next_st.log_ptr = BASE_IRQ_LOG; // [RL19]
      end else begin
        next_st.log_ptr = st.log_ptr + LOG_STEP; // [RL19]
      end
    end

    if (i_rst) begin
      next_st = '0;
      next_st.fsm = HRPM_ST_IDLE;
      next_st.region = HRPM_RG_REGS;
      next_st.log_ptr = BASE_IRQ_LOG; // [RL19]
    end
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_data = st.rdata;
  assign o_data_oe = st.par_oe;
  assign o_wait = st.wait_pin;
  assign o_so = st.spi_out[DATA_W - 1];
  assign o_so_oe = st.so_oe;
  assign o_mem_rd = st.mem_rd;
  assign o_mem_wr = st.mem_wr;
  assign o_mem_addr = st.mem_addr;
  assign o_mem_wdata = st.mem_wdata;
  assign o_mem_region = st.region;
  assign o_irq_log_ptr = st.log_ptr;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_miss_waits;
    @(posedge i_clk) disable iff (i_rst)
    (st.fsm == HRPM_ST_IDLE && st.pend_rd && !st.pend_wr && !(st.pf_valid && st.pend_addr == st.pf_addr))
    |=> st.wait_act && st.mem_rd ##1 st.wait_act ##1 !st.wait_act && st.rdy;
  endproperty
  a_miss_waits: assert property (p_miss_waits) else $error("Read miss did not wait for its fetch."); // [RL1]

  property p_read_prefetches;
    @(posedge i_clk) disable iff (i_rst)
    st.rdy |-> st.mem_rd && st.mem_addr == st.cur_addr + ADDR_ONE ##2 st.fsm == HRPM_ST_IDLE;
  endproperty
  a_read_prefetches: assert property (p_read_prefetches) else $error("Read did not prefetch the next word."); // [RL2]

  property p_hit_no_wait;
    @(posedge i_clk) disable iff (i_rst)
    (st.fsm == HRPM_ST_IDLE && st.pend_rd && !st.pend_wr && st.pf_valid && st.pend_addr == st.pf_addr)
    |=> !st.wait_act && st.rdy && st.rdata == $past(st.pf_data);
  endproperty
  a_hit_no_wait: assert property (p_hit_no_wait) else $error("Prefetch hit did not return held data at once."); // [RL3]

  property p_write_invalidates;
    @(posedge i_clk) disable iff (i_rst)
    st.mem_wr |-> !st.pf_valid;
  endproperty
  a_write_invalidates: assert property (p_write_invalidates) else $error("Write left the prefetch valid."); // [RL4]

  property p_prefetch_lands;
    @(posedge i_clk) disable iff (i_rst)
    (st.fsm == HRPM_ST_PREF && !st.mem_rd && !st.pend_wr) |=> st.pf_valid && st.pf_addr == $past(st.mem_addr);
  endproperty
  a_prefetch_lands: assert property (p_prefetch_lands) else $error("Prefetch word not held."); // [RL5]

  property p_wait_polarity;
    @(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && $stable(pol_s) |-> st.wait_pin == (st.wait_act ~^ pol_s);
  endproperty
  a_wait_polarity: assert property (p_wait_polarity) else $error("Wait output level ignores the polarity strap."); // [RL6]

  property p_so_quiet;
    @(posedge i_clk) disable iff (i_rst)
    st.so_oe |-> $past(!ss_s) && $past(!bus_sel_s) && st.spi_is_rd;
  endproperty
  a_so_quiet: assert property (p_so_quiet) else $error("Serial output driven outside a read frame."); // [RL8]

  property p_port_select;
    @(posedge i_clk) disable iff (i_rst)
    st.par_oe |-> $past(bus_sel_s);
  endproperty
  a_port_select: assert property (p_port_select) else $error("Parallel data driven while serial port selected."); // [RL9]

  property p_reserved_zero;
    @(posedge i_clk) disable iff (i_rst)
    (st.fsm == HRPM_ST_FETCH && !st.mem_rd && cur_region == HRPM_RG_RSVD) |=> st.rdata == DATA_ZERO;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved word did not read as zero."); // [RL10]

  property p_log_step;
    @(posedge i_clk) disable iff (i_rst)
    i_irq_log_advance |=> (st.log_ptr == $past(st.log_ptr) + LOG_STEP) || (st.log_ptr == BASE_IRQ_LOG);
  endproperty
  a_log_step: assert property (p_log_step) else $error("Interrupt log pointer did not advance one entry."); // [RL19]
endmodule

// ### hrpm_mem_model.sv
// Behavioural model of the shared register and RAM storage behind the host port.
// Assumes the same clock as the port and answers a read strobe on the following cycle.

// ----------------------------------------------------------------------------
// Storage model
// ----------------------------------------------------------------------------
module hrpm_mem_model (
  input wire logic i_clk,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic [14:0] i_mem_addr,
  input wire logic [15:0] i_mem_wdata,
  output logic [15:0] o_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [14:0]];

  initial o_mem_rdata = 16'h0000;

  // Outside the answer cycle the data toggles, so a late capture cannot match by luck.
  always @(posedge i_clk) begin
    if (i_mem_wr) begin
      mem[i_mem_addr] = i_mem_wdata;
    end
    if (i_mem_rd) begin
      o_mem_rdata <= mem.exists(i_mem_addr) ? mem[i_mem_addr] : {i_mem_addr, 1'b1} ^ 16'hA5C3;
    end else begin
      o_mem_rdata <= ~o_mem_rdata;
    end
  end
endmodule

// ### tb.sv
// Self-checking testbench of the host port: parallel reads and writes, prefetch, map, log pointer, serial port.
// Assumes the storage model beside the port and a 10 MHz clock.
module tb;
  import hrpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst, i_bus_sel, pol, i_ce_n, i_oe_n, i_we_n, i_ss_n, i_sck, i_si, i_irq_log_advance;
  logic [14:0] i_addr, o_mem_addr, o_irq_log_ptr, rd_a, last_rd;
  logic [15:0] i_data, i_mem_rdata, o_data, o_mem_wdata;
  logic o_data_oe, o_wait, o_so, o_so_oe, o_mem_rd, o_mem_wr, rd_d;
  hrpm_region_type o_mem_region;
  int n_errors, n_tests, rd_cnt;
  logic [15:0] shadow [logic [14:0]];

  hrpm_host_port i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus_sel(i_bus_sel), .i_hold_off_polarity_strap(pol),
    .i_ce_n(i_ce_n), .i_oe_n(i_oe_n), .i_we_n(i_we_n), .i_addr(i_addr), .i_data(i_data), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_wait(o_wait), .i_ss_n(i_ss_n), .i_sck(i_sck), .i_si(i_si), .o_so(o_so),
    .o_so_oe(o_so_oe), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .o_mem_region(o_mem_region),
    .i_irq_log_advance(i_irq_log_advance), .o_irq_log_ptr(o_irq_log_ptr));
  hrpm_mem_model i_mem (.i_clk(i_clk), .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [15:0] exp_word(input logic [14:0] a);
    if (a >= 15'h0050 && a <= 15'h0053) return 16'h0000;
    return shadow.exists(a) ? shadow[a] : {a, 1'b1} ^ 16'hA5C3;
  endfunction

  function automatic hrpm_region_type exp_region(input logic [14:0] a);
    logic [14:0] b [15];
    b = '{15'h0050, 15'h0054, 15'h005C, 15'h0086, 15'h00B0, 15'h00B8, 15'h00C0, 15'h0100,
          15'h0180, 15'h01C0, 15'h01E0, 15'h0200, 15'h0300, 15'h0400, 15'h0800};
    for (int i = 14; i >= 0; i--) begin
      if (a >= b[i]) return hrpm_region_type'(4'(i + 1));
    end
    return HRPM_RG_REGS;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic done(input string s);
    $display("%s finished, mismatches so far %0d", s, n_errors);
  endtask

  // Every storage read is judged one cycle later, when its region code lines up with the data.
  always @(negedge i_clk) begin
    if (i_rst) begin
      rd_d = 1'b0;
    end else begin
      if (rd_d) chk(16'(o_mem_region), 16'(exp_region(rd_a)));
      rd_d = o_mem_rd;
      if (o_mem_rd === 1'b1) begin
        rd_a = o_mem_addr;
        last_rd = o_mem_addr;
        rd_cnt++;
      end
    end
  end

  task automatic pread(input logic [14:0] a, output logic [15:0] d, output logic sw);
    @(posedge i_clk) i_addr <= a;
    cyc(4);
    i_ce_n <= 1'b0;
    i_oe_n <= 1'b0;
    sw = 1'b0;
    repeat (14) begin
      @(negedge i_clk);
      if (o_wait === pol) sw = 1'b1;
    end
    d = o_data;
    chk(16'(o_data_oe), 16'h0001);
    @(posedge i_clk) i_ce_n <= 1'b1;
    i_oe_n <= 1'b1;
    cyc(6);
  endtask

  task automatic pwrite(input logic [14:0] a, input logic [15:0] d);
    logic ok;
    shadow[a] = d;
    ok = 1'b0;
    @(posedge i_clk) i_addr <= a;
    i_data <= d;
    cyc(4);
    i_ce_n <= 1'b0;
    i_we_n <= 1'b0;
    cyc(4);
    i_we_n <= 1'b1;
    @(posedge i_clk) i_ce_n <= 1'b1;
    repeat (16) begin
      @(negedge i_clk);
      if (o_mem_wr === 1'b1 && !ok) begin
        ok = 1'b1;
        chk(16'(o_mem_addr), 16'(a));
        chk(o_mem_wdata, d);
      end
    end
    chk(16'(ok), 16'h0001);
  endtask

  // Mode 0 word: data set while the serial clock is low, sampled after it rises.
  task automatic spi_xfer(input logic [15:0] w, output logic [15:0] r, output logic oe_all);
    oe_all = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge i_clk) i_si <= w[i];
      cyc(4);
      i_sck <= 1'b1;
      cyc(4);
      @(negedge i_clk);
      r[i] = o_so;
      if (o_so_oe !== 1'b1) oe_all = 1'b0;
      @(posedge i_clk) i_sck <= 1'b0;
      cyc(3);
    end
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_miss_hit;
    logic [15:0] d;
    logic sw;
    pread(15'h0900, d, sw);
    chk(16'(sw), 16'h0001);
    chk(d, exp_word(15'h0900));
    cyc(50);
    pread(15'h0901, d, sw);
    chk(16'(sw), 16'h0000);
    chk(d, exp_word(15'h0901));
    pread(15'h0A00, d, sw);
    chk(16'(last_rd), 16'h0A01);
    done("miss_hit");
  endtask

  task automatic t_write;
    logic [15:0] d;
    logic sw;
    pread(15'h0910, d, sw);
    pwrite(15'h0911, 16'hBEEF);
    pread(15'h0911, d, sw);
    chk(16'(sw), 16'h0001);
    chk(d, 16'hBEEF);
    done("write_break");
  endtask

  task automatic t_pol;
    logic [15:0] d;
    logic sw;
    @(posedge i_clk) pol <= 1'b0;
    cyc(6);
    chk(16'(o_wait), 16'h0001);
    pread(15'h0920, d, sw);
    chk(16'(sw), 16'h0001);
    chk(d, exp_word(15'h0920));
    @(posedge i_clk) pol <= 1'b1;
    cyc(6);
    chk(16'(o_wait), 16'h0000);
    done("polarity");
  endtask

  task automatic t_map;
    logic [15:0] d;
    logic sw;
    logic [14:0] tab [32];
    tab = '{15'h0000, 15'h004F, 15'h0050, 15'h0053, 15'h0054, 15'h005B, 15'h005C, 15'h0085,
            15'h0086, 15'h00AF, 15'h00B0, 15'h00B7, 15'h00B8, 15'h00BF, 15'h00C0, 15'h00FF,
            15'h0100, 15'h017F, 15'h0180, 15'h01BF, 15'h01C0, 15'h01DF, 15'h01E0, 15'h01FF,
            15'h0200, 15'h02FF, 15'h0300, 15'h03FF, 15'h0400, 15'h07FF, 15'h0800, 15'h7FFF};
    foreach (tab[i]) begin
      pread(tab[i], d, sw);
      chk(d, exp_word(tab[i]));
    end
    done("address_map");
  endtask

  task automatic t_irq;
    logic [14:0] p;
    p = 15'h0180;
    chk(16'(o_irq_log_ptr), 16'h0180);
    repeat (33) begin
      @(posedge i_clk) i_irq_log_advance <= 1'b1;
      @(posedge i_clk) i_irq_log_advance <= 1'b0;
      cyc(2);
      p = (p == 15'h01BE) ? 15'h0180 : p + 15'h0002;
      chk(16'(o_irq_log_ptr), 16'(p));
    end
    @(posedge i_clk) i_rst <= 1'b1;
    cyc(2);
    i_rst <= 1'b0;
    cyc(6);
    chk(16'(o_irq_log_ptr), 16'h0180);
    done("irq_log");
  endtask

  task automatic t_spi;
    logic [15:0] r;
    logic oe;
    int n0;
    @(posedge i_clk) i_bus_sel <= 1'b0;
    cyc(6);
    n0 = rd_cnt;
    i_addr <= 15'h0940;
    cyc(4);
    i_ce_n <= 1'b0;
    i_oe_n <= 1'b0;
    cyc(10);
    chk(16'(o_data_oe), 16'h0000);
    i_ce_n <= 1'b1;
    i_oe_n <= 1'b1;
    cyc(6);
    chk(16'(rd_cnt - n0), 16'h0000);
    chk(16'(o_so_oe), 16'h0000);
    i_ss_n <= 1'b0;
    cyc(4);
    spi_xfer({1'b1, 15'h0930}, r, oe);
    cyc(20);
    spi_xfer(16'h0000, r, oe);
    chk(r, exp_word(15'h0930));
    chk(16'(oe), 16'h0001);
    cyc(20);
    spi_xfer(16'h0000, r, oe);
    chk(r, exp_word(15'h0931));
    @(posedge i_clk) i_ss_n <= 1'b1;
    cyc(6);
    chk(16'(o_so_oe), 16'h0000);
    i_ss_n <= 1'b0;
    cyc(4);
    spi_xfer({1'b0, 15'h0935}, r, oe);
    spi_xfer(16'h1234, r, oe);
    chk(16'(oe), 16'h0000);
    shadow[15'h0935] = 16'h1234;
    i_ss_n <= 1'b1;
    cyc(6);
    i_ss_n <= 1'b0;
    cyc(4);
    spi_xfer({1'b1, 15'h0935}, r, oe);
    cyc(20);
    spi_xfer(16'h0000, r, oe);
    chk(r, exp_word(15'h0935));
    i_ss_n <= 1'b1;
    cyc(6);
    chk(16'(o_so_oe), 16'h0000);
    i_bus_sel <= 1'b1;
    cyc(6);
    done("serial");
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    results();
  end

  initial begin
    {i_rst, i_bus_sel, pol, i_ce_n, i_oe_n, i_we_n, i_ss_n} = 7'h7F;
    {i_sck, i_si, i_irq_log_advance, rd_d} = 4'h0;
    i_addr = 15'h0000;
    i_data = 16'h0000;
    {n_errors, n_tests, rd_cnt} = '0;
    cyc(4);
    i_rst <= 1'b0;
    cyc(6);
    t_irq();
    t_miss_hit();
    t_write();
    t_pol();
    t_map();
    t_spi();
    results();
  end
endmodule
